//--- logic/mgmt_pkg.sv
// Constants, types and field layouts of the management register bank
package mgmt_pkg;
   // ---------------------------------------------------------------
   // Register offsets and indirect targets
   // ---------------------------------------------------------------
   localparam logic [4:0] REG_BASIC_CONTROL = 5'h00;
   localparam logic [4:0] REG_BASIC_STATUS = 5'h01;
   localparam logic [4:0] REG_PHY_IDENT_HIGH = 5'h02;
   localparam logic [4:0] REG_PHY_IDENT_LOW = 5'h03;
   localparam logic [4:0] REG_INDIRECT_MMD_SELECT = 5'h0d;
   localparam logic [4:0] REG_INDIRECT_MMD_WINDOW = 5'h0e;
   localparam logic [4:0] MMD_MEDIUM = 5'h01;
   localparam logic [4:0] MMD_CODING = 5'h03;
   localparam logic [4:0] MMD_AUTONEG = 5'h07;
   localparam logic [4:0] MMD_VENDOR = 5'h1e;
   localparam logic [15:0] ADDR_STD_CONTROL = 16'h0000;
   localparam logic [15:0] ADDR_T1L_MEDIUM_CONTROL = 16'h08f6;
   localparam logic [15:0] ADDR_T1L_CODING_CONTROL = 16'h08e6;
   localparam logic [15:0] ADDR_AUTONEG_CONTROL = 16'h0200;
   localparam logic [15:0] ADDR_VENDOR_SOFT_RESET = 16'h8810;
   localparam logic [15:0] ADDR_VENDOR_POWER_DOWN = 16'h8812;
   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int BIT_SOFT_RESET = 15;
   localparam int BIT_LOOP = 14;
   localparam int BIT_AUTONEG_EN = 12;
   localparam int BIT_POWER_DOWN = 11;
   localparam int BIT_DETACH = 10;
   localparam int BIT_FULL_DUPLEX = 8;
   localparam int BIT_VENDOR_PD = 0;
   localparam int BIT_TEN_FD = 12;
   localparam int BIT_AN_DONE = 5;
   localparam int BIT_AN_ABLE = 3;
   localparam int BIT_LINK = 2;
   localparam int BIT_EXT_REGS = 0;
   localparam logic [15:0] BASIC_CONTROL_RESET = 16'h1100;
   localparam logic [15:0] BASIC_STATUS_RESET = 16'h1009;
   localparam logic AUTONEG_ENABLE_RESET = 1'b1;
   // Arbitrary identification values, not those of any real part
   localparam logic [15:0] IDENT_HIGH_VALUE = 16'h1a2b;
   localparam logic [15:0] IDENT_LOW_VALUE = 16'h3c4d;
   // ---------------------------------------------------------------
   // Frame and indirect access encodings
   // ---------------------------------------------------------------
   localparam logic [1:0] OP_WRITE = 2'b01;
   localparam logic [1:0] OP_READ = 2'b10;
   localparam logic [5:0] PREAMBLE_BITS = 6'h20;
   localparam logic [3:0] HEADER_LAST = 4'hb;
   localparam logic [3:0] DATA_LAST = 4'hf;
   localparam logic [1:0] FUNC_ADDRESS = 2'b00;
   localparam logic [1:0] FUNC_DATA = 2'b01;
   localparam logic [1:0] FUNC_DATA_INC_RW = 2'b10;
   localparam logic [1:0] FUNC_DATA_INC_WR = 2'b11;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int START_UP_NS = 2000;
   localparam int START_UP_CYCLES = (START_UP_NS * CLK_MHZ + 999) / 1000;
   localparam logic [1:0] STRAP_SETTLE = 2'h3;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_START = 5'h02,
      ST_HEADER = 5'h04,
      ST_TURN = 5'h08,
      ST_DATA = 5'h10
   } frame_state_e;
   typedef struct packed {
      logic soft_reset_request;
      logic pcs_local_loop_enable;
      logic autoneg_enable_mirror;
      logic soft_power_down;
      logic mac_side_detach;
   } ctrl_s;
   typedef struct packed {
      logic mdc;
      logic mdio;
      logic link_up;
      logic autoneg_done;
      logic power_down_strap;
      logic [4:0] phy_addr;
   } pins_s;
   typedef struct packed {
      logic [1:0] func;
      logic [4:0] devad;
   } mmd_sel_s;
endpackage

//--- logic/clause22_mgmt_register_bank.sv
// Clause 22 management register bank with MDIO slave and indirect Indirect_mmd_window
`timescale 1ns/1ps
module clause22_mgmt_register_bank #(
   parameter logic [15:0] IDENT_HIGH = mgmt_pkg::IDENT_HIGH_VALUE,
   parameter logic [15:0] IDENT_LOW = mgmt_pkg::IDENT_LOW_VALUE,
   parameter int START_UP_CYC = mgmt_pkg::START_UP_CYCLES
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Management link, two-way data split in three
   input wire logic mdc_i,
   input wire logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe_n_o,
   // Engine status and straps
   input wire logic link_up_i,
   input wire logic autoneg_done_i,
   input wire logic power_down_strap_i,
   input wire logic [4:0] phy_addr_strap_i,
   // Control towards the engines
   output mgmt_pkg::ctrl_s ctrl_o
);
   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   mgmt_pkg::pins_s pins_raw; // Raw asynchronous inputs
   mgmt_pkg::pins_s meta_ff; // First synchroniser stage
   mgmt_pkg::pins_s sync_ff; // Second stage, the only one logic reads
   logic mdc_d_ff; // Previous clock level for edge finding
   logic link_d_ff; // Previous link level
   logic mdc_rise; // Rising management clock edge
   logic [1:0] init_cnt_ff; // Settle count before straps are caught
   logic [4:0] phy_addr_ff; // Captured address strap
   logic pd_strap_ff; // Captured power-down strap
   mgmt_pkg::frame_state_e state_ff;
   logic [5:0] pre_cnt_ff; // Run of ones seen as preamble
   logic [3:0] bit_cnt_ff; // Position inside current field
   logic [11:0] hdr_ff; // Op, PHY address, register address
   logic [15:0] data_sh_ff; // Incoming data bits
   logic [11:0] nxt_hdr;
   logic [15:0] wr_data;
   logic rd_take; // Read header accepted this cycle
   logic wr_take; // Write frame complete this cycle
   logic [15:0] out_sh_ff; // Outgoing read data
   logic reading_ff; // Read in progress
   mgmt_pkg::ctrl_s ctrl_ff;
   logic [31:0] sr_cnt_ff; // Start-up timer of soft reset cycle
   logic fail_ff; // Link dropped since last status read or soft reset
   mgmt_pkg::mmd_sel_s sel_ff;
   logic [15:0] mmd_addr_ff;
   logic mmd_wr;
   logic mmd_rd;
   logic sr_start;
   logic status_rd;

   assign pins_raw = '{mdc: mdc_i, mdio: mdio_i, link_up: link_up_i,
      autoneg_done: autoneg_done_i, power_down_strap: power_down_strap_i,
      phy_addr: phy_addr_strap_i};

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   // Two stages for every pin; edge finder looks only at second stage
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_ff <= '0;
         sync_ff <= '0;
         mdc_d_ff <= 1'b0;
         link_d_ff <= 1'b0;
      end else begin
         meta_ff <= pins_raw;
         sync_ff <= meta_ff;
         mdc_d_ff <= sync_ff.mdc;
         link_d_ff <= sync_ff.link_up;
      end
   end

   assign mdc_rise = sync_ff.mdc & ~mdc_d_ff;

   // ---------------------------------------------------------------
   // Strap capture after reset release
   // ---------------------------------------------------------------
   // Straps are caught only once synchronisers hold settled values
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         init_cnt_ff <= 2'h0;
         phy_addr_ff <= 5'h00;
         pd_strap_ff <= 1'b0;
      end else if (init_cnt_ff != mgmt_pkg::STRAP_SETTLE) begin
         init_cnt_ff <= init_cnt_ff + 2'h1;
         if (init_cnt_ff == mgmt_pkg::STRAP_SETTLE - 2'h1) begin
            phy_addr_ff <= sync_ff.phy_addr;
            pd_strap_ff <= sync_ff.power_down_strap;
         end
      end
   end

   // ---------------------------------------------------------------
   // Frame receiver
   // ---------------------------------------------------------------
   assign nxt_hdr = {hdr_ff[10:0], sync_ff.mdio};
   assign wr_data = {data_sh_ff[14:0], sync_ff.mdio};
   assign rd_take = mdc_rise && state_ff == mgmt_pkg::ST_HEADER &&
      bit_cnt_ff == mgmt_pkg::HEADER_LAST && nxt_hdr[11:10] == mgmt_pkg::OP_READ &&
      nxt_hdr[9:5] == phy_addr_ff;
   assign wr_take = mdc_rise && state_ff == mgmt_pkg::ST_DATA &&
      bit_cnt_ff == mgmt_pkg::DATA_LAST && hdr_ff[11:10] == mgmt_pkg::OP_WRITE &&
      hdr_ff[9:5] == phy_addr_ff;

   // Every frame must open with a full preamble; none may be skipped
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_ff <= mgmt_pkg::ST_IDLE;
         pre_cnt_ff <= 6'h00;
         bit_cnt_ff <= 4'h0;
         hdr_ff <= 12'h000;
         data_sh_ff <= 16'h0000;
      end else if (mdc_rise) begin
         case (state_ff)
            mgmt_pkg::ST_IDLE: begin
               // Count ones, a zero after a full run is the start bit
               if (sync_ff.mdio) begin
                  if (pre_cnt_ff != mgmt_pkg::PREAMBLE_BITS) begin
                     pre_cnt_ff <= pre_cnt_ff + 6'h01;
                  end
               end else begin
                  if (pre_cnt_ff == mgmt_pkg::PREAMBLE_BITS) begin
                     state_ff <= mgmt_pkg::ST_START;
                  end
                  pre_cnt_ff <= 6'h00;
               end
            end
            mgmt_pkg::ST_START: begin
               // Second start bit must be one, else start over
               state_ff <= sync_ff.mdio ? mgmt_pkg::ST_HEADER : mgmt_pkg::ST_IDLE;
               bit_cnt_ff <= 4'h0;
            end
            mgmt_pkg::ST_HEADER: begin
               hdr_ff <= nxt_hdr;
               bit_cnt_ff <= bit_cnt_ff + 4'h1;
               if (bit_cnt_ff == mgmt_pkg::HEADER_LAST) begin
                  state_ff <= mgmt_pkg::ST_TURN;
                  bit_cnt_ff <= 4'h0;
               end
            end
            mgmt_pkg::ST_TURN: begin
               // Two turnaround bits
               bit_cnt_ff <= bit_cnt_ff + 4'h1;
               if (bit_cnt_ff == 4'h1) begin
                  state_ff <= mgmt_pkg::ST_DATA;
                  bit_cnt_ff <= 4'h0;
               end
            end
            mgmt_pkg::ST_DATA: begin
               // Sixteen data bits, most significant first
               data_sh_ff <= wr_data;
               bit_cnt_ff <= bit_cnt_ff + 4'h1;
               if (bit_cnt_ff == mgmt_pkg::DATA_LAST) begin
                  state_ff <= mgmt_pkg::ST_IDLE;
                  bit_cnt_ff <= 4'h0;
               end
            end
            default: begin
               state_ff <= mgmt_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Read images
   // ---------------------------------------------------------------
   // Shared image of the control word; all aliases read this same state
   function automatic logic [15:0] ctrl_image();
      logic [15:0] v;
      v = 16'h0000; // Speed, one-way, collision, reserved read zero
      v[mgmt_pkg::BIT_SOFT_RESET] = ctrl_ff.soft_reset_request;
      v[mgmt_pkg::BIT_LOOP] = ctrl_ff.pcs_local_loop_enable;
      v[mgmt_pkg::BIT_AUTONEG_EN] = ctrl_ff.autoneg_enable_mirror;
      v[mgmt_pkg::BIT_POWER_DOWN] = ctrl_ff.soft_power_down;
      v[mgmt_pkg::BIT_DETACH] = ctrl_ff.mac_side_detach;
      v[mgmt_pkg::BIT_FULL_DUPLEX] = 1'b1;
      return v;
   endfunction

   // Status word; unsupported abilities and faults stay zero
   function automatic logic [15:0] status_image();
      logic [15:0] v;
      v = 16'h0000;
      v[mgmt_pkg::BIT_TEN_FD] = 1'b1;
      v[mgmt_pkg::BIT_AN_DONE] = sync_ff.autoneg_done;
      v[mgmt_pkg::BIT_AN_ABLE] = 1'b1;
      v[mgmt_pkg::BIT_LINK] = sync_ff.link_up & ~fail_ff;
      v[mgmt_pkg::BIT_EXT_REGS] = 1'b1;
      return v;
   endfunction

   // Indirect targets that hold mirrored bits; others read zero
   function automatic logic [15:0] mmd_image(input logic [4:0] dev, input logic [15:0] a);
      logic [15:0] v;
      v = 16'h0000;
      if ((dev == mgmt_pkg::MMD_MEDIUM || dev == mgmt_pkg::MMD_CODING) &&
          a == mgmt_pkg::ADDR_STD_CONTROL) begin
         v[mgmt_pkg::BIT_SOFT_RESET] = ctrl_ff.soft_reset_request;
         if (dev == mgmt_pkg::MMD_CODING) begin
            v[mgmt_pkg::BIT_LOOP] = ctrl_ff.pcs_local_loop_enable;
         end
      end else if ((dev == mgmt_pkg::MMD_MEDIUM && a == mgmt_pkg::ADDR_T1L_MEDIUM_CONTROL) ||
                   (dev == mgmt_pkg::MMD_CODING && a == mgmt_pkg::ADDR_T1L_CODING_CONTROL) ||
                   (dev == mgmt_pkg::MMD_VENDOR && a == mgmt_pkg::ADDR_VENDOR_SOFT_RESET)) begin
         v[mgmt_pkg::BIT_SOFT_RESET] = ctrl_ff.soft_reset_request;
      end else if (dev == mgmt_pkg::MMD_VENDOR && a == mgmt_pkg::ADDR_VENDOR_POWER_DOWN) begin
         v[mgmt_pkg::BIT_VENDOR_PD] = ctrl_ff.soft_power_down;
      end else if (dev == mgmt_pkg::MMD_AUTONEG && a == mgmt_pkg::ADDR_AUTONEG_CONTROL) begin
         v[mgmt_pkg::BIT_AUTONEG_EN] = ctrl_ff.autoneg_enable_mirror;
      end
      return v;
   endfunction

   // Register image selected by the Clause 22 address
   function automatic logic [15:0] c22_image(input logic [4:0] r);
      logic [15:0] v;
      v = 16'h0000; // Unimplemented addresses read zero
      case (r)
         mgmt_pkg::REG_BASIC_CONTROL: v = ctrl_image();
         mgmt_pkg::REG_BASIC_STATUS: v = status_image();
         mgmt_pkg::REG_PHY_IDENT_HIGH: v = IDENT_HIGH;
         mgmt_pkg::REG_PHY_IDENT_LOW: v = IDENT_LOW;
         mgmt_pkg::REG_INDIRECT_MMD_SELECT: v = {sel_ff.func, 9'h000, sel_ff.devad};
         mgmt_pkg::REG_INDIRECT_MMD_WINDOW: begin
            v = (sel_ff.func == mgmt_pkg::FUNC_ADDRESS) ? mmd_addr_ff :
               mmd_image(sel_ff.devad, mmd_addr_ff);
         end
         default: v = 16'h0000;
      endcase
      return v;
   endfunction

   // ---------------------------------------------------------------
   // Read data driver
   // ---------------------------------------------------------------
   // Drive zero in second turnaround bit, then data; release after last
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         out_sh_ff <= 16'h0000;
         reading_ff <= 1'b0;
         mdio_o <= 1'b1;
         mdio_oe_n_o <= 1'b1;
      end else if (rd_take) begin
         out_sh_ff <= c22_image(nxt_hdr[4:0]);
         reading_ff <= 1'b1;
      end else if (mdc_rise && reading_ff) begin
         if (state_ff == mgmt_pkg::ST_TURN && bit_cnt_ff == 4'h0) begin
            mdio_o <= 1'b0;
            mdio_oe_n_o <= 1'b0;
         end else if (state_ff == mgmt_pkg::ST_DATA && bit_cnt_ff == mgmt_pkg::DATA_LAST) begin
            reading_ff <= 1'b0;
            mdio_o <= 1'b1;
            mdio_oe_n_o <= 1'b1;
         end else begin
            mdio_o <= out_sh_ff[15];
            out_sh_ff <= {out_sh_ff[14:0], 1'b0};
         end
      end
   end

   // ---------------------------------------------------------------
   // Write and read decode
   // ---------------------------------------------------------------
   assign mmd_wr = wr_take && hdr_ff[4:0] == mgmt_pkg::REG_INDIRECT_MMD_WINDOW &&
      sel_ff.func != mgmt_pkg::FUNC_ADDRESS;
   assign mmd_rd = rd_take && nxt_hdr[4:0] == mgmt_pkg::REG_INDIRECT_MMD_WINDOW &&
      sel_ff.func != mgmt_pkg::FUNC_ADDRESS;
   assign status_rd = rd_take && nxt_hdr[4:0] == mgmt_pkg::REG_BASIC_STATUS;

   function automatic logic hit(input logic [4:0] dev, input logic [15:0] a);
      return mmd_wr && sel_ff.devad == dev && mmd_addr_ff == a;
   endfunction

   function automatic logic ctrl_wr();
      return wr_take && hdr_ff[4:0] == mgmt_pkg::REG_BASIC_CONTROL;
   endfunction

   // Any alias of the reset bit reaches the one stored bit
   // Process form so that signals read inside the functions wake it
   always_comb begin
      sr_start = wr_data[mgmt_pkg::BIT_SOFT_RESET] && (ctrl_wr() ||
         hit(mgmt_pkg::MMD_MEDIUM, mgmt_pkg::ADDR_STD_CONTROL) ||
         hit(mgmt_pkg::MMD_MEDIUM, mgmt_pkg::ADDR_T1L_MEDIUM_CONTROL) ||
         hit(mgmt_pkg::MMD_CODING, mgmt_pkg::ADDR_STD_CONTROL) ||
         hit(mgmt_pkg::MMD_CODING, mgmt_pkg::ADDR_T1L_CODING_CONTROL) ||
         hit(mgmt_pkg::MMD_VENDOR, mgmt_pkg::ADDR_VENDOR_SOFT_RESET));
   end

   // ---------------------------------------------------------------
   // Control bits
   // ---------------------------------------------------------------
   // Soft reset restores defaults at once, then holds for start-up time
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_ff <= '{1'b0, 1'b0, mgmt_pkg::AUTONEG_ENABLE_RESET, 1'b0, 1'b0};
         sr_cnt_ff <= 32'h0000_0000;
      end else if (init_cnt_ff == mgmt_pkg::STRAP_SETTLE - 2'h1) begin
         ctrl_ff.soft_power_down <= sync_ff.power_down_strap;
      end else if (sr_start) begin
         ctrl_ff <= '{1'b1, 1'b0, mgmt_pkg::AUTONEG_ENABLE_RESET, pd_strap_ff, 1'b0};
         sr_cnt_ff <= 32'h0000_0000;
      end else begin
         if (ctrl_ff.soft_reset_request) begin
            // Self clear once start-up has run out
            sr_cnt_ff <= sr_cnt_ff + 32'h0000_0001;
            if (sr_cnt_ff == 32'(START_UP_CYC - 1)) begin
               ctrl_ff.soft_reset_request <= 1'b0;
            end
         end
         // Only writable bits take data; constant bits are dropped
         if (ctrl_wr()) begin
            ctrl_ff.pcs_local_loop_enable <= wr_data[mgmt_pkg::BIT_LOOP];
            ctrl_ff.soft_power_down <= wr_data[mgmt_pkg::BIT_POWER_DOWN];
            ctrl_ff.mac_side_detach <= wr_data[mgmt_pkg::BIT_DETACH];
         end
         if (hit(mgmt_pkg::MMD_CODING, mgmt_pkg::ADDR_STD_CONTROL)) begin
            ctrl_ff.pcs_local_loop_enable <= wr_data[mgmt_pkg::BIT_LOOP];
         end
         if (hit(mgmt_pkg::MMD_VENDOR, mgmt_pkg::ADDR_VENDOR_POWER_DOWN)) begin
            ctrl_ff.soft_power_down <= wr_data[mgmt_pkg::BIT_VENDOR_PD];
         end
         if (hit(mgmt_pkg::MMD_AUTONEG, mgmt_pkg::ADDR_AUTONEG_CONTROL)) begin
            ctrl_ff.autoneg_enable_mirror <= wr_data[mgmt_pkg::BIT_AUTONEG_EN];
         end
      end
   end

   assign ctrl_o = ctrl_ff;

   // ---------------------------------------------------------------
   // Link latch
   // ---------------------------------------------------------------
   // A drop seen in the cycle of a status read still latches
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fail_ff <= 1'b0;
      end else if (link_d_ff && !sync_ff.link_up) begin
         fail_ff <= 1'b1;
      end else if (status_rd || sr_start) begin
         fail_ff <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Indirect access registers
   // ---------------------------------------------------------------
   // Address steps after the access when the function asks for it
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sel_ff <= '0;
         mmd_addr_ff <= 16'h0000;
      end else if (sr_start) begin
         sel_ff <= '0;
         mmd_addr_ff <= 16'h0000;
      end else if (wr_take && hdr_ff[4:0] == mgmt_pkg::REG_INDIRECT_MMD_SELECT) begin
         sel_ff <= '{wr_data[15:14], wr_data[4:0]}; // Reserved middle bits dropped
      end else if (wr_take && hdr_ff[4:0] == mgmt_pkg::REG_INDIRECT_MMD_WINDOW) begin
         if (sel_ff.func == mgmt_pkg::FUNC_ADDRESS) begin
            mmd_addr_ff <= wr_data;
         end else if (sel_ff.func != mgmt_pkg::FUNC_DATA) begin
            mmd_addr_ff <= mmd_addr_ff + 16'h0001;
         end
      end else if (mmd_rd && sel_ff.func == mgmt_pkg::FUNC_DATA_INC_RW) begin
         mmd_addr_ff <= mmd_addr_ff + 16'h0001;
      end
   end
endmodule

//--- tb/clause22_mgmt_register_bank_properties.sv
// Port checks of the management register bank
`timescale 1ns/1ps
module clause22_mgmt_register_bank_properties #(
   parameter int START_UP_CYC = 8
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic mdc_i,
   input wire logic mdio_o,
   input wire logic mdio_oe_n_o,
   input wire mgmt_pkg::ctrl_s ctrl_o
);
   localparam int LO = START_UP_CYC - 2;
   localparam int HI = START_UP_CYC + 2;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   AST_RESET_CTRL: assert property ($rose(rst_n_i) |-> ctrl_o == 5'h04)
      else $error("control not at reset value");
   AST_SR_HOLD: assert property ($rose(ctrl_o.soft_reset_request) |=>
      ctrl_o.soft_reset_request[*4]) else $error("soft reset dropped early");
   AST_SR_CLEAR: assert property ($rose(ctrl_o.soft_reset_request) |-> ##[LO:HI]
      !ctrl_o.soft_reset_request) else $error("soft reset not self-cleared");
   AST_SR_DEFAULTS: assert property ($rose(ctrl_o.soft_reset_request) |-> ##[1:2]
      (!ctrl_o.pcs_local_loop_enable && !ctrl_o.mac_side_detach)) else $error("no defaults");
   AST_TA_ZERO: assert property ($fell(mdio_oe_n_o) |-> !mdio_o)
      else $error("turnaround bit not zero");
   AST_DRIVE_HOLD: assert property ($fell(mdio_oe_n_o) |=> !mdio_oe_n_o[*8])
      else $error("drive window too short");
   AST_IDLE_HIGH: assert property (mdio_oe_n_o |-> mdio_o)
      else $error("idle data not high");
   AST_BIT_ON_MDC: assert property (!mdio_oe_n_o && $changed(mdio_o) |-> mdc_i)
      else $error("data changed away from clock rise");
   AST_CTRL_ON_MDC: assert property ($changed(ctrl_o.pcs_local_loop_enable) ||
      $changed(ctrl_o.mac_side_detach) |-> mdc_i) else $error("control changed off frame");
   COV_READ: cover property ($rose(mdio_oe_n_o));
   COV_SR: cover property ($fell(ctrl_o.soft_reset_request));
   COV_LOOP: cover property ($rose(ctrl_o.pcs_local_loop_enable));
endmodule
bind clause22_mgmt_register_bank clause22_mgmt_register_bank_properties #(
   .START_UP_CYC(START_UP_CYC)) i_props (.clock_i(clock_i), .rst_n_i(rst_n_i),
   .mdc_i(mdc_i), .mdio_o(mdio_o), .mdio_oe_n_o(mdio_oe_n_o), .ctrl_o(ctrl_o));

//--- tb/mdio_host_model.sv
// Management link master: frames with preamble, clock still between frames
`timescale 1ns/1ps
module mdio_host_model (
   output logic mdc_o,
   output logic mdio_o,
   input wire logic dev_mdio_i,
   input wire logic dev_oe_n_i
);
   logic hd = 1'b1; // Host data bit
   logic he = 1'b1; // Host drives the wire
   logic tog = 1'b0; // Undriven wire wanders, no pull-up modelled
   int pre = 32; // Preamble length in ones; shortened only to test refusal
   initial mdc_o = 1'b0;
   always @(mdc_o) tog <= ~tog;
   assign mdio_o = !dev_oe_n_i ? dev_mdio_i : (he ? hd : tog);
   // Preamble of pre ones before every frame, full at the default of 32
   task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
         input logic [15:0] wd, output logic [15:0] rd);
      logic [63:0] f;
      f = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
      rd = 16'h0000;
      for (int i = 31 + pre; i >= 0; i--) begin
         he = !(op == mgmt_pkg::OP_READ && i < 18);
         hd = f[i];
         #32 mdc_o = 1'b1;
         if (i < 16) rd[i] = mdio_o;
         #32 mdc_o = 1'b0;
      end
      he = 1'b1;
      hd = 1'b1;
   endtask
endmodule

//--- tb/clause22_mgmt_register_bank_bench.sv
// Self-checking bench of the management register bank
`timescale 1ns/1ps
module clause22_mgmt_register_bank_bench;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic mdc, mdio, mdio_o, oe_n, link = 1'b0, an = 1'b0, strap = 1'b0;
   logic [4:0] pa = 5'h00;
   mgmt_pkg::ctrl_s ctrl;
   logic [15:0] got, dflt;
   logic [15:0] exp_q[$];
   int errors = 0, num_checks = 0, cyc = 0;
   integer seed = 32'hb49c;
   event seen;
   initial forever #2.5 clock_i = ~clock_i;
   clause22_mgmt_register_bank #(.START_UP_CYC(8)) i_clause22_mgmt_register_bank (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .mdc_i(mdc), .mdio_i(mdio), .mdio_o(mdio_o),
      .mdio_oe_n_o(oe_n), .link_up_i(link), .autoneg_done_i(an),
      .power_down_strap_i(strap), .phy_addr_strap_i(pa), .ctrl_o(ctrl));
   mdio_host_model i_mdio_host_model (.mdc_o(mdc), .mdio_o(mdio), .dev_mdio_i(mdio_o),
      .dev_oe_n_i(oe_n));
   task automatic check(input logic [15:0] s, input logic [15:0] e);
      num_checks++;
      if (s !== e) begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [4:0] ra, input logic [15:0] d, input logic [4:0] p = pa);
      logic [15:0] x;
      i_mdio_host_model.xfer(mgmt_pkg::OP_WRITE, p, ra, d, x);
   endtask
   task automatic rd(input logic [4:0] ra, input logic [15:0] e);
      exp_q.push_back(e);
      i_mdio_host_model.xfer(mgmt_pkg::OP_READ, pa, ra, 16'h0000, got);
      ->seen;
      @(negedge clock_i);
   endtask
   // Watcher takes the oldest note whenever a read completes
   always @(seen) check(got, exp_q.pop_front());
   task automatic ind(input logic [4:0] dev, input logic [15:0] a, input logic [15:0] d);
      wr(5'h0d, {mgmt_pkg::FUNC_ADDRESS, 9'h000, dev});
      wr(5'h0e, a);
      wr(5'h0d, {mgmt_pkg::FUNC_DATA, 9'h000, dev});
      wr(5'h0e, d);
   endtask
   task automatic end_sim();
      if (errors == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 40000) begin
         errors++;
         end_sim();
      end
   end
   initial begin
      {pa, strap} = 6'($random(seed));
      repeat (12) @(negedge clock_i);
      rst_n_i = 1'b1;
      repeat (20) @(negedge clock_i);
      dflt = {4'h1, strap, 3'h1, 8'h00};
      rd(5'h00, dflt);
      rd(5'h01, mgmt_pkg::BASIC_STATUS_RESET);
      rd(5'h02, mgmt_pkg::IDENT_HIGH_VALUE);
      wr(5'h00, 16'h7fff);
      check(16'(ctrl), 16'h000f);
      rd(5'h00, 16'h5d00);
      wr(5'h00, 16'h8000);
      rd(5'h00, dflt);
      ind(mgmt_pkg::MMD_CODING, 16'h0000, 16'h4000);
      rd(5'h00, dflt | 16'h4000);
      ind(mgmt_pkg::MMD_VENDOR, mgmt_pkg::ADDR_VENDOR_POWER_DOWN, 16'h0001);
      rd(5'h00, dflt | 16'h4800);
      rd(5'h0e, 16'h0001);
      wr(5'h0d, {mgmt_pkg::FUNC_DATA_INC_RW, 9'h000, mgmt_pkg::MMD_VENDOR});
      rd(5'h0e, 16'h0001);
      rd(5'h0e, 16'h0000);
      wr(5'h0d, {mgmt_pkg::FUNC_DATA_INC_WR, 9'h000, mgmt_pkg::MMD_VENDOR});
      rd(5'h0e, 16'h0000);
      wr(5'h0e, 16'h0000);
      wr(5'h0d, {mgmt_pkg::FUNC_ADDRESS, 9'h000, mgmt_pkg::MMD_VENDOR});
      rd(5'h0e, 16'h8815);
      ind(mgmt_pkg::MMD_VENDOR, mgmt_pkg::ADDR_VENDOR_SOFT_RESET, 16'h8000);
      rd(5'h00, dflt);
      wr(5'h00, 16'h4000, pa ^ 5'h01);
      rd(5'h00, dflt);
      i_mdio_host_model.pre = 31;
      wr(5'h00, 16'h4000);
      i_mdio_host_model.pre = 32;
      rd(5'h00, dflt);
      wr(5'h00, got | 16'h0400);
      rd(5'h00, dflt | 16'h0400);
      @(negedge clock_i);
      link = 1'b1;
      an = 1'b1;
      repeat (10) @(negedge clock_i);
      rd(5'h01, 16'h102d);
      link = 1'b0;
      repeat (10) @(negedge clock_i);
      link = 1'b1;
      repeat (10) @(negedge clock_i);
      rd(5'h01, 16'h1029);
      rd(5'h01, 16'h102d);
      end_sim();
   end
endmodule
